// ==== mmbc_bus_ctrl.sv ====
// minimum mode bus control sequencer with hold handshake
// Overview of operation
// RULE1: memory/io select high for memory, low for io cycles
// RULE2: select valid from T4 before the cycle through the final T4
// RULE3: select, direction, enable and write float high during hold
// RULE4: write strobe low in T2, T3 and wait states of writes
// RULE5: interrupt acknowledge strobe low in T2, T3 and wait states
// RULE6: interrupt acknowledge strobe is always driven
// RULE7: address latch pulse high during clock low of T1
// RULE8: address latch pulse is always driven
// RULE9: direction high transmit, low receive, timed like the select
// RULE10: transceiver enable low in every memory, io and acknowledge cycle
// RULE11: reads and acknowledges enable from mid T2 to mid T4
// RULE12: writes enable from start of T2 to mid T4
// RULE13: other master holds request high until done
// RULE14: grant rises in the middle of T4 or idle state
// RULE15: bus and control lines float as grant rises
// RULE16: grant drops after request low; drive again on next cycle
// RULE17: other master presents request synchronous to the clock
// RULE18: addressed device drives ready low to stretch with waits
// RULE19: cycle runs T1, T2, T3, waits while ready low, then T4
`include "mmbc_regs.svh"
`default_nettype none
module mmbc_bus_ctrl
   import mmbc_pkg::*;
(
   input  wire logic      core_clk_i,
   input  wire logic      sys_rst_i,
   input  wire logic      req_valid_i,
   input  wire mmbc_req_s req_i,
   output logic           req_ready_o,
   input  wire logic      ready_i,
   input  wire logic      hold_req_i,
   output logic           bus_grant_out_o,
   output mmbc_ctl_s      ctl_o,
   output logic           ctl_oe_o,
   output logic           ad_oe_o,
   output logic           int_ack_strobe_n_o,
   output logic           addr_latch_o,
   output logic           clk_phase_o,
   output logic           cycle_state_o
);
   ////////////////////////////////////////////////////////////////////////
   // state: each T state spans two core clocks, phase low then high
   mmbc_state_e state_ff, nxt_state;
   logic        phase_ff, nxt_phase;
   mmbc_req_s   cur_ff, nxt_cur;
   logic        pend_ff, nxt_pend;
   mmbc_req_s   pnd_ff, nxt_pnd;
   logic        grant_ff, nxt_grant;
   logic        drive_ff, nxt_drive;
   mmbc_ctl_s   ctl_ff, nxt_ctl;
   logic        int_ack_strobe_n_n_ff, nxt_int_ack_strobe_n_n;
   logic        ale_ff, nxt_ale;

   // next state and next pin values
   always_comb begin
      nxt_state  = state_ff;
      nxt_phase  = ~phase_ff;
      nxt_cur    = cur_ff;
      nxt_pend   = pend_ff;
      nxt_pnd    = pnd_ff;
      nxt_grant  = grant_ff;
      nxt_drive  = drive_ff;
      nxt_ctl    = ctl_ff;
      nxt_int_ack_strobe_n_n = 1'h1;
      nxt_ale    = 1'h0;
      // slot only loads at the end of a high phase, so a request is always
      // seen for a full low phase before the sequencer can start it
      if (req_valid_i && !pend_ff && phase_ff == `MMBC_PH_HI) begin
         nxt_pend = 1'h1;
         nxt_pnd  = req_i;
      end
      if (phase_ff == `MMBC_PH_HI) begin
         unique case (state_ff)
            MMBC_IDLE, MMBC_T4: begin
               // hold decided in the low phase; grant already up here
               if (grant_ff) begin
                  nxt_state = MMBC_HOLD; // [RULE14]
               end else if (pend_ff) begin // [RULE19]
                  nxt_state = MMBC_T1;
                  nxt_cur   = pnd_ff;
                  nxt_pend  = 1'h0;
                  nxt_ale   = 1'h1; // [RULE7]
               end else begin
                  nxt_state = MMBC_IDLE;
               end
            end
            MMBC_T1: begin
               nxt_state = MMBC_T2;
               // writes open the transceiver right at the start of T2
               if (cur_ff.cmd == `MMBC_CMD_WR) begin
                  nxt_ctl.xcvr_enable_n = 1'h0; // [RULE12]
               end
            end
            MMBC_T2: nxt_state = MMBC_T3;
            MMBC_T3, MMBC_TW: begin
               nxt_state = ready_i ? MMBC_T4 : MMBC_TW; // [RULE19]
            end
            MMBC_HOLD: begin
               if (!grant_ff) begin
                  nxt_state = MMBC_IDLE; // [RULE16]
               end
            end
         endcase
      end else begin
         // mid-cycle pin updates in the low phase of a T state
         unique case (state_ff)
            MMBC_IDLE, MMBC_T4: begin
               nxt_ctl.xcvr_enable_n = 1'h1; // [RULE11] [RULE12]
               nxt_ctl.wr_strobe_n   = 1'h1;
               if (hold_req_i) begin
                  nxt_grant = 1'h1; // [RULE14]
                  nxt_drive = 1'h0; // [RULE15]
               end else if (pend_ff) begin
                  nxt_ctl.mem_io_sel = pnd_ff.is_mem ? `MMBC_SEL_MEM
                                                     : `MMBC_SEL_IO;
                  nxt_ctl.xcvr_direction = (pnd_ff.cmd == `MMBC_CMD_WR) ?
                     `MMBC_DIR_TX : `MMBC_DIR_RX; // [RULE2] [RULE9] [RULE1]
                  nxt_drive = 1'h1;
               end
            end
            MMBC_T2: begin
               nxt_ctl.xcvr_enable_n = 1'h0; // [RULE10] [RULE11]
            end
            MMBC_HOLD: begin
               // grant follows the request; low grant ends hold next phase
               nxt_grant = hold_req_i; // [RULE16]
            end
            default: ;
         endcase
      end
      if (state_ff == MMBC_T3 && phase_ff == `MMBC_PH_LO &&
          !ready_i) begin
         nxt_ctl.wr_strobe_n = 1'h0;
      end
      // strobes hold through T2, T3 and waits
      if ((state_ff == MMBC_T2 || state_ff == MMBC_T3 ||
           state_ff == MMBC_TW) && !(phase_ff == `MMBC_PH_HI &&
           state_ff != MMBC_T2 && ready_i)) begin
         nxt_int_ack_strobe_n_n = (cur_ff.cmd == `MMBC_CMD_INT_ACK_STROBE_N) ? 1'h0 : 1'h1; // [RULE5]
         nxt_ctl.wr_strobe_n = (cur_ff.cmd == `MMBC_CMD_WR) ? 1'h0
                                                            : 1'h1; // [RULE4]
      end else if (state_ff != MMBC_T1) begin
         nxt_ctl.wr_strobe_n = 1'h1;
      end
      // strobes fall at the T1 to T2 boundary, not inside T1
      if (state_ff == MMBC_T1 && phase_ff == `MMBC_PH_HI) begin
         nxt_ctl.wr_strobe_n = (cur_ff.cmd == `MMBC_CMD_WR) ? 1'h0 : 1'h1;
         nxt_int_ack_strobe_n_n = (cur_ff.cmd == `MMBC_CMD_INT_ACK_STROBE_N) ? 1'h0 : 1'h1; // [RULE5]
      end
   end

   // registers only
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state_ff  <= MMBC_IDLE;
         phase_ff  <= `MMBC_PH_LO;
         cur_ff    <= '0;
         pend_ff   <= 1'h0;
         pnd_ff    <= '0;
         grant_ff  <= 1'h0;
         drive_ff  <= 1'h0;
         ctl_ff    <= '1;
         int_ack_strobe_n_n_ff <= 1'h1;
         ale_ff    <= 1'h0;
      end else begin
         state_ff  <= nxt_state;
         phase_ff  <= nxt_phase;
         cur_ff    <= nxt_cur;
         pend_ff   <= nxt_pend;
         pnd_ff    <= nxt_pnd;
         grant_ff  <= nxt_grant;
         drive_ff  <= nxt_drive;
         ctl_ff    <= nxt_ctl;
         int_ack_strobe_n_n_ff <= nxt_int_ack_strobe_n_n;
         ale_ff    <= nxt_ale;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs; floated lines show logic one when not driven
   assign req_ready_o        = ~pend_ff & phase_ff;
   assign bus_grant_out_o    = grant_ff; // [RULE14]
   assign ctl_oe_o           = drive_ff & ~grant_ff; // [RULE3] [RULE15]
   assign ad_oe_o            = drive_ff & ~grant_ff; // [RULE15]
   assign ctl_o              = ctl_oe_o ? ctl_ff : '1; // [RULE3]
   assign int_ack_strobe_n_o = int_ack_strobe_n_n_ff; // [RULE6]
   assign addr_latch_o       = ale_ff; // [RULE8]
   assign clk_phase_o        = phase_ff;
   assign cycle_state_o      = (state_ff != MMBC_IDLE) &&
                               (state_ff != MMBC_HOLD);

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_grant_floats;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      bus_grant_out_o |-> !ctl_oe_o && ctl_o == '1;
   endproperty
   a_grant_floats: assert property (p_grant_floats) // [RULE3]
      else $error("control lines driven during grant");

   property p_ale_t1;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      addr_latch_o |-> state_ff == MMBC_T1;
   endproperty
   a_ale_t1: assert property (p_ale_t1) // [RULE7]
      else $error("address latch pulse outside T1");

   property p_int_ack_strobe_n_only;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      !int_ack_strobe_n_o |-> cur_ff.cmd == `MMBC_CMD_INT_ACK_STROBE_N &&
         state_ff inside {MMBC_T2, MMBC_T3, MMBC_TW, MMBC_T4};
   endproperty
   a_int_ack_strobe_n_only: assert property (p_int_ack_strobe_n_only) // [RULE5]
      else $error("acknowledge strobe in wrong state");

   property p_wr_only;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      !ctl_o.wr_strobe_n |-> cur_ff.cmd == `MMBC_CMD_WR;
   endproperty
   a_wr_only: assert property (p_wr_only) // [RULE4]
      else $error("write strobe outside write cycle");

   property p_wait_ready;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      state_ff == MMBC_T3 && phase_ff && !ready_i |=> state_ff == MMBC_TW;
   endproperty
   a_wait_ready: assert property (p_wait_ready) // [RULE19]
      else $error("no wait state on low ready");

   property p_grant_release;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      state_ff == MMBC_HOLD && !hold_req_i && !phase_ff |=> !grant_ff;
   endproperty
   a_grant_release: assert property (p_grant_release) // [RULE16]
      else $error("grant kept after request low");

   property p_en_t3;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      state_ff == MMBC_T3 && drive_ff |-> !ctl_o.xcvr_enable_n;
   endproperty
   a_en_t3: assert property (p_en_t3) // [RULE10]
      else $error("transceiver disabled in T3");

   property p_grant_mid;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      $rose(grant_ff) |-> phase_ff && $past(state_ff) inside
         {MMBC_IDLE, MMBC_T4};
   endproperty
   a_grant_mid: assert property (p_grant_mid) // [RULE14]
      else $error("grant rose outside T4 or idle");

   property p_ale_low;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      addr_latch_o |-> phase_ff == `MMBC_PH_LO;
   endproperty
   a_ale_low: assert property (p_ale_low) // [RULE7]
      else $error("address latch pulse outside clock low of T1");

   property p_sel_stable;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      state_ff inside {MMBC_T1, MMBC_T2, MMBC_T3, MMBC_TW} |=>
         $stable(ctl_ff.mem_io_sel) && $stable(ctl_ff.xcvr_direction);
   endproperty
   a_sel_stable: assert property (p_sel_stable) // [RULE2] [RULE9]
      else $error("select or direction changed inside a cycle");

   property p_sel_kind;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      state_ff == MMBC_T1 |-> ctl_o.mem_io_sel == cur_ff.is_mem;
   endproperty
   a_sel_kind: assert property (p_sel_kind) // [RULE1]
      else $error("select does not match access kind");

   property p_hold_strobes;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      bus_grant_out_o |-> int_ack_strobe_n_o && !addr_latch_o;
   endproperty
   a_hold_strobes: assert property (p_hold_strobes) // [RULE6] [RULE8]
      else $error("strobe active during grant");

   property p_wr_t2;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      state_ff == MMBC_T2 && cur_ff.cmd == `MMBC_CMD_WR |->
         !ctl_o.wr_strobe_n && !ctl_o.xcvr_enable_n;
   endproperty
   a_wr_t2: assert property (p_wr_t2) // [RULE4] [RULE12]
      else $error("write strobe or enable missing in T2");

   property p_rd_en_late;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      state_ff == MMBC_T2 && !phase_ff && cur_ff.cmd != `MMBC_CMD_WR |->
         ctl_o.xcvr_enable_n;
   endproperty
   a_rd_en_late: assert property (p_rd_en_late) // [RULE11]
      else $error("read enable before middle of T2");

   property p_en_t4;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      state_ff == MMBC_T4 && !bus_grant_out_o |->
         ctl_o.xcvr_enable_n == phase_ff;
   endproperty
   a_en_t4: assert property (p_en_t4) // [RULE11] [RULE12]
      else $error("enable not released in the middle of T4");

   property p_grant_states;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      grant_ff |-> state_ff inside {MMBC_IDLE, MMBC_T4, MMBC_HOLD};
   endproperty
   a_grant_states: assert property (p_grant_states) // [RULE15]
      else $error("bus cycle running during grant");

   property p_release_float;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      $fell(grant_ff) |-> !ctl_oe_o && !ad_oe_o;
   endproperty
   a_release_float: assert property (p_release_float) // [RULE16]
      else $error("bus driven right after grant release");
endmodule
`default_nettype wire

// ==== mmbc_mem_model.sv ====
// memory and io responder that stretches bus cycles with wait states
`default_nettype none
module mmbc_mem_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       en_n_i,
   input  wire logic       phase_i,
   input  wire logic [3:0] waits_i,
   output logic            ready_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_ff;
   // count high phases while the transceiver is enabled
   always_ff @(posedge clk_i) begin
      if (rst_i || en_n_i) cnt_ff <= 4'h0;
      else if (phase_i && cnt_ff != 4'hF) cnt_ff <= cnt_ff + 4'h1;
   end
   // low until the programmed number of phases has passed
   assign ready_o = (cnt_ff >= waits_i);
endmodule
`default_nettype wire

// ==== mmbc_pkg.sv ====
// types shared by the minimum mode bus control block
`default_nettype none
package mmbc_pkg;
   typedef enum logic [2:0] {
      MMBC_IDLE = 3'h0,
      MMBC_T1   = 3'h1,
      MMBC_T2   = 3'h2,
      MMBC_T3   = 3'h3,
      MMBC_TW   = 3'h4,
      MMBC_T4   = 3'h5,
      MMBC_HOLD = 3'h6
   } mmbc_state_e;

   // one bus cycle request from the execution side
   typedef struct packed {
      logic       is_mem;
      logic [1:0] cmd;
   } mmbc_req_s;

   // floatable control pins, values only; the drive enable is ctl_oe_o
   typedef struct packed {
      logic mem_io_sel;
      logic xcvr_direction;
      logic xcvr_enable_n;
      logic wr_strobe_n;
   } mmbc_ctl_s;
endpackage
`default_nettype wire

// ==== mmbc_regs.svh ====
// timing and encoding constants for the minimum mode bus control block
`ifndef MMBC_REGS_SVH
`define MMBC_REGS_SVH
`define MMBC_PH_LO      1'h0
`define MMBC_PH_HI      1'h1
`define MMBC_SEL_MEM    1'h1
`define MMBC_SEL_IO     1'h0
`define MMBC_DIR_TX     1'h1
`define MMBC_DIR_RX     1'h0
`define MMBC_CMD_RD     2'h0
`define MMBC_CMD_WR     2'h1
`define MMBC_CMD_INT_ACK_STROBE_N   2'h2
`endif

// ==== testbench.sv ====
// self-checking bench for the minimum mode bus control block
`include "mmbc_regs.svh"
`default_nettype none
module testbench
   import mmbc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, rv, rdy_in, hreq, rrdy, gnt, coe, aoe, ia_n, ale, ph, cyc;
   logic [3:0] waits;
   mmbc_req_s  req;
   mmbc_ctl_s  ctl;
   int n_fail, checks;
   mmbc_bus_ctrl dut_u (.core_clk_i(clk), .sys_rst_i(rst), .req_valid_i(rv),
      .req_i(req), .req_ready_o(rrdy), .ready_i(rdy_in), .hold_req_i(hreq),
      .bus_grant_out_o(gnt), .ctl_o(ctl), .ctl_oe_o(coe), .ad_oe_o(aoe),
      .int_ack_strobe_n_o(ia_n), .addr_latch_o(ale), .clk_phase_o(ph),
      .cycle_state_o(cyc));
   mmbc_mem_model mem_u (.clk_i(clk), .rst_i(rst), .en_n_i(ctl.xcvr_enable_n),
      .phase_i(ph), .waits_i(waits), .ready_o(rdy_in));
   ////////////////////////////////////////////////////////////////////////
   // clock generator
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // count a comparison and report a mismatch
   task automatic chk(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // wait at falling edges until a signal reaches a level, bounded
   task automatic wait_lvl(ref logic s, input logic v, input int lim);
      int n;
      n = 0;
      while (s !== v && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // values held during reset
   task automatic t_reset();
      chk(gnt === 1'b0 && ctl === 4'hF && coe === 1'b0, "reset outputs");
      chk(ia_n === 1'b1 && ale === 1'b0 && aoe === 1'b0, "reset strobes");
      $display("reset test done");
   endtask
   // one bus cycle of a given kind, watched clock by clock
   task automatic run_cycle(input logic m, input logic [1:0] c,
                            input logic [3:0] w);
      int n, na;
      logic s_ale, s_wr, s_ia, s_en, ok, en2, wr;
      s_ale = 0; s_wr = 0; s_ia = 0; s_en = 0; ok = 1; en2 = 0;
      na = 0;
      wr = (c == `MMBC_CMD_WR);
      waits = w;
      req = '{is_mem: m, cmd: c};
      rv = 1'b1;
      wait_lvl(rrdy, 1'b1, 50);
      @(negedge clk);
      rv = 1'b0;
      wait_lvl(cyc, 1'b1, 60);
      n = 0;
      while (cyc === 1'b1 && n < 300) begin
         s_ale |= ale;
         if (ale === 1'b1) na++;
         s_wr |= ~ctl.wr_strobe_n;
         s_ia |= ~ia_n;
         s_en |= ~ctl.xcvr_enable_n;
         if (ctl.mem_io_sel !== m || ctl.xcvr_direction !== wr) ok = 0;
         if (ia_n === 1'bz || ale === 1'bz || coe !== 1'b1) ok = 0;
         if (n == 2) en2 = ctl.xcvr_enable_n;
         @(negedge clk);
         n++;
      end
      chk(ok, "select, direction or drive wrong");
      chk(s_ale === 1'b1 && na == 1, "address latch pulse");
      chk(s_wr === wr, "write strobe wrong");
      chk(s_ia === (c == `MMBC_CMD_INT_ACK_STROBE_N), "acknowledge strobe");
      chk(s_en === 1'b1, "transceiver never enabled");
      chk(en2 === ~wr, "enable at start of T2");
      chk(w == 0 ? n == 8 : n > 8, "cycle length");
   endtask
   // every command to memory without waits and to io with two wait states
   task automatic t_cycles();
      for (int c = 0; c < 3; c++) begin
         run_cycle(1'b1, c[1:0], 4'h0);
         run_cycle(1'b0, c[1:0], 4'h3);
      end
      $display("cycle test done");
   endtask
   // hold handshake with a request pending meanwhile
   task automatic t_hold();
      hreq = 1'b1;
      wait_lvl(gnt, 1'b1, 40);
      chk(gnt === 1'b1, "no grant");
      chk(ctl === 4'hF && coe === 1'b0 && aoe === 1'b0, "not floated");
      chk(ale === 1'b0 && ia_n === 1'b1, "strobes not driven");
      req = '{is_mem: 1'b1, cmd: `MMBC_CMD_RD};
      rv = 1'b1;
      repeat (20) @(negedge clk);
      rv = 1'b0;
      chk(cyc === 1'b0 && gnt === 1'b1 && coe === 1'b0, "cycle in hold");
      hreq = 1'b0;
      wait_lvl(gnt, 1'b0, 20);
      chk(gnt === 1'b0, "grant kept");
      wait_lvl(cyc, 1'b1, 60);
      chk(cyc === 1'b1 && coe === 1'b1, "no cycle after hold");
      wait_lvl(cyc, 1'b0, 60);
      $display("hold test done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   // watchdog
   initial begin
      #(25 * 5000);
      n_fail++;
      $display("unexpected at %0t: watchdog expired", $time);
      finish_test();
   end
   // main sequence
   initial begin
      n_fail = 0;
      checks = 0;
      rst = 1'b1;
      rv = 1'b0;
      hreq = 1'b0;
      waits = 4'h0;
      req = '0;
      repeat (3) @(negedge clk);
      t_reset();
      rst = 1'b0;
      @(negedge clk);
      t_cycles();
      t_hold();
      finish_test();
   end
endmodule
`default_nettype wire
